// >>> common/lgr_pkg.sv
package lgr_pkg;
  // clock and 8 MHz position count
  localparam int CLK_MHZ = 100;
  localparam int XCLK_MHZ = 8;
  localparam logic [6:0] ACC_STEP = 7'(XCLK_MHZ);
  localparam logic [6:0] ACC_WRAP = 7'(CLK_MHZ - XCLK_MHZ);
  // link clock half period made by the host
  localparam int SCK_HALF_NS = 80;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS * CLK_MHZ) / 1000;
  // poll bytes
  localparam logic [7:0] CMD_START = 8'h01;
  localparam logic [7:0] CMD_READ = 8'h42;
  localparam logic [7:0] ID_TAIL = 8'h5A;
  localparam logic [7:0] IRQ_EN_ON = 8'h10;
  localparam logic [7:0] IRQ_EN_OFF = 8'h00;
  localparam logic [7:0] HIZ_BYTE = 8'hFF;
  localparam logic [7:0] IDLE_BYTE = 8'h00;
  // identification low bytes, values arbitrary
  localparam logic [7:0] ID_VIDEO_LO = 8'h73;
  localparam logic [7:0] ID_IRQ_LO = 8'h12;
  // coordinate error codes
  localparam logic [15:0] ERR_X = 16'h0001;
  localparam logic [15:0] ERR_Y_VSYNC = 16'h0005;
  localparam logic [15:0] ERR_Y_NONE = 16'h000A;
  // button bit positions
  localparam int BTN_LEFT = 3;
  localparam int BTN_V_TRIG = 13;
  localparam int BTN_RIGHT = 14;
  localparam int BTN_I_TRIG = 15;
  localparam logic [15:0] BTN_IDLE = 16'hFFFF;
  // poll lengths in bytes
  localparam logic [3:0] LEN_SHORT = 4'h5;
  localparam logic [3:0] LEN_LONG = 4'h9;
  // host register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_ID = 8'h08;
  localparam logic [7:0] A_BTN = 8'h0C;
  localparam logic [7:0] A_XPOS = 8'h10;
  localparam logic [7:0] A_YPOS = 8'h14;
  localparam logic [7:0] A_ISTAT = 8'h18;
  localparam logic [7:0] A_IMASK = 8'h1C;
  // host fields
  localparam int CTRL_START = 0;
  localparam int CTRL_LONG = 1;
  localparam int CTRL_EN_LSB = 8;
  localparam int IST_DONE = 0;
  localparam int IST_GUN = 1;
  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_GAP = 4'h2,
    H_LOW = 4'h4,
    H_HIGH = 4'h8
  } lgr_hstate_t;
endpackage

// >>> common/lgr_if.sv
`timescale 1ns/100ps
interface lgr_if;
  logic sel_n;
  logic sck;
  logic cmd;
  logic dat_o;
  logic dat_oe;
  logic dat;
  logic lightgun_interrupt;
  // open-drain data line with pull-up
  assign dat = !(dat_oe && !dat_o);
  modport dev (input sel_n, input sck, input cmd, input dat, output dat_o,
    output dat_oe, output lightgun_interrupt);
  modport host (output sel_n, output sck, output cmd, input dat,
    input lightgun_interrupt);
endinterface

// >>> rtl/lgr_sync.sv
`timescale 1ns/100ps
module lgr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out,
  output logic [W-1:0] rise_out,
  output logic [W-1:0] fall_out
);
  logic [W-1:0] m_q;
  logic [W-1:0] s_q;
  logic [W-1:0] p_q;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      m_q <= INIT;
      s_q <= INIT;
      p_q <= INIT;
    end else begin
      m_q <= d_in;
      s_q <= m_q;
      p_q <= s_q;
    end
  end

  assign q_out = s_q;
  assign rise_out = s_q & ~p_q;
  assign fall_out = ~s_q & p_q;
endmodule

// >>> rtl/lgr_gun.sv
// What this block does
// - video timing taken from separate hsync and vsync inputs
// - video gun sends own fixed identification
// - video buttons: bit3 left, 13 trigger, 14 right
// - x counts 8 MHz ticks since hsync
// - y counts scanlines since vsync
// - light in vsync reports 0001h/0005h
// - no light yet reports 0001h/000Ah
// - coordinates refresh every frame regardless
// - host polls after vblank, before vsync
// - host reads one or two guns per frame
// - poll 01 42 00 en 00, reply HiZ id 5A buttons
// - fourth byte 10h enables interrupt, 00h disables
// - interrupt gun sends distinct identification
// - interrupt buttons: bit3 start, 14 rear, 15 trigger
// - interrupt gun sends no coordinates, pulses line
// - host latches position on gun interrupt; this host latches only ISTAT bit 1, no position
// - host services interrupt without long delay
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module lgr_gun (
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  lgr_if.dev LINK,
  input wire logic HSYNC_IN,
  input wire logic VSYNC_IN,
  input wire logic LIGHT_IN,
  input wire logic TRIGGER_N_IN,
  input wire logic LEFT_N_IN,
  input wire logic RIGHT_N_IN,
  input wire logic IRQ_TYPE_IN,
  output logic BUSY_OUT,
  output logic IRQ_EN_OUT
);
  ////////////////////////////////////////////////////////////////////////
  logic [9:0] s;
  logic [9:0] r;
  logic [9:0] f;
  logic sel_n_s;
  logic sck_s;
  logic cmd_s;
  logic hs_s;
  logic vs_s;
  logic lt_s;
  logic type_s;

  // idle levels avoid false edges on reset release
  lgr_sync #(.W(10), .INIT(10'h1C7)) u_sync (
    .clk_in(CLK_IN),
    .srst_in(SRST_IN),
    .d_in({IRQ_TYPE_IN, RIGHT_N_IN, LEFT_N_IN, TRIGGER_N_IN, LIGHT_IN,
      VSYNC_IN, HSYNC_IN, LINK.cmd, LINK.sck, LINK.sel_n}),
    .q_out(s),
    .rise_out(r),
    .fall_out(f)
  );

  assign sel_n_s = s[0];
  assign sck_s = s[1];
  assign cmd_s = s[2];
  assign hs_s = s[3];
  assign vs_s = s[4];
  assign lt_s = s[5];
  assign type_s = s[9];

  ////////////////////////////////////////////////////////////////////////
  logic [6:0] acc_q;
  logic tick;
  logic [15:0] hcnt_q;
  logic [15:0] vcnt_q;

  assign tick = acc_q >= lgr_pkg::ACC_WRAP;

  // fractional divider: 8 ticks per 100 clocks
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      acc_q <= 7'h00;
    end else if (tick) begin
      acc_q <= acc_q - lgr_pkg::ACC_WRAP;
    end else begin
      acc_q <= acc_q + lgr_pkg::ACC_STEP;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      hcnt_q <= 16'h0000;
    end else if (r[3]) begin
      hcnt_q <= 16'h0000;
    end else if (tick && hcnt_q != 16'hFFFF) begin
      hcnt_q <= hcnt_q + 16'h0001;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      vcnt_q <= 16'h0000;
    end else if (r[4]) begin
      vcnt_q <= 16'h0000;
    end else if (r[3] && vcnt_q != 16'hFFFF) begin
      vcnt_q <= vcnt_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic hit_q;
  logic err_q;
  logic [15:0] hx_q;
  logic [15:0] vy_q;
  logic [15:0] rep_x;
  logic [15:0] rep_y;

  // frame restarts at vsync; light inside vsync is stray light
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      hit_q <= 1'b0;
      err_q <= 1'b0;
      hx_q <= 16'h0000;
      vy_q <= 16'h0000;
    end else begin
      err_q <= (err_q & ~r[4]) | (r[5] & (vs_s | r[4]));
      if (r[4]) begin
        hit_q <= 1'b0;
      end else if (r[5] && !vs_s && !hit_q) begin
        hit_q <= 1'b1;
        hx_q <= hcnt_q;
        vy_q <= vcnt_q;
      end
    end
  end

  always_comb begin
    if (err_q) begin
      rep_x = lgr_pkg::ERR_X;
      rep_y = lgr_pkg::ERR_Y_VSYNC;
    end else if (hit_q) begin
      rep_x = hx_q;
      rep_y = vy_q;
    end else begin
      rep_x = lgr_pkg::ERR_X;
      rep_y = lgr_pkg::ERR_Y_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic [15:0] snap_x_q;
  logic [15:0] snap_y_q;
  logic [15:0] snap_btn_q;
  logic snap_irq_q;
  logic [15:0] btn;

  always_comb begin
    btn = lgr_pkg::BTN_IDLE;
    btn[lgr_pkg::BTN_LEFT] = s[7];
    btn[lgr_pkg::BTN_RIGHT] = s[8];
    if (type_s) begin
      btn[lgr_pkg::BTN_I_TRIG] = s[6];
    end else begin
      btn[lgr_pkg::BTN_V_TRIG] = s[6];
    end
  end

  // one frame's pair is frozen for the whole poll
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      snap_x_q <= lgr_pkg::ERR_X;
      snap_y_q <= lgr_pkg::ERR_Y_NONE;
      snap_btn_q <= lgr_pkg::BTN_IDLE;
      snap_irq_q <= 1'b0;
    end else if (f[0]) begin
      snap_x_q <= rep_x;
      snap_y_q <= rep_y;
      snap_btn_q <= btn;
      snap_irq_q <= type_s;
    end
  end

  function automatic logic [7:0] reply(input logic [3:0] idx);
    logic [7:0] b;
    b = lgr_pkg::HIZ_BYTE;
    unique case (idx)
      4'h1: b = snap_irq_q ? lgr_pkg::ID_IRQ_LO : lgr_pkg::ID_VIDEO_LO;
      4'h2: b = lgr_pkg::ID_TAIL;
      4'h3: b = snap_btn_q[7:0];
      4'h4: b = snap_btn_q[15:8];
      4'h5: b = snap_irq_q ? lgr_pkg::HIZ_BYTE : snap_x_q[7:0];
      4'h6: b = snap_irq_q ? lgr_pkg::HIZ_BYTE : snap_x_q[15:8];
      4'h7: b = snap_irq_q ? lgr_pkg::HIZ_BYTE : snap_y_q[7:0];
      4'h8: b = snap_irq_q ? lgr_pkg::HIZ_BYTE : snap_y_q[15:8];
      default: b = lgr_pkg::HIZ_BYTE;
    endcase
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic act_q;
  logic [2:0] bit_q;
  logic [3:0] byte_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic oe_q;
  logic irq_en_q;
  logic lgi_q;
  logic rx_done;
  logic [7:0] rx_val;

  assign rx_done = act_q && r[1] && bit_q == 3'h7;
  assign rx_val = {cmd_s, rx_q[7:1]};

  // bits lsb first: drive on falling, sample on rising link clock
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      act_q <= 1'b0;
      bit_q <= 3'h0;
      byte_q <= 4'h0;
      rx_q <= 8'h00;
      tx_q <= lgr_pkg::HIZ_BYTE;
      oe_q <= 1'b0;
    end else if (r[0]) begin
      act_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (f[0]) begin
      act_q <= 1'b1;
      bit_q <= 3'h0;
      byte_q <= 4'h0;
      tx_q <= lgr_pkg::HIZ_BYTE;
      oe_q <= 1'b0;
    end else if (act_q && !sel_n_s && f[1]) begin
      oe_q <= ~tx_q[bit_q];
    end else if (act_q && !sel_n_s && r[1]) begin
      rx_q <= rx_val;
      bit_q <= bit_q + 3'h1;
      if (rx_done) begin
        tx_q <= reply(byte_q + 4'h1);
        byte_q <= (byte_q == 4'hF) ? byte_q : byte_q + 4'h1;
        // a foreign command frees the line until deselect
        if ((byte_q == 4'h0 && rx_val != lgr_pkg::CMD_START)
            || (byte_q == 4'h1 && rx_val != lgr_pkg::CMD_READ)) begin
          act_q <= 1'b0;
          oe_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      irq_en_q <= 1'b0;
    end else if (rx_done && byte_q == 4'h3) begin
      irq_en_q <= rx_val == lgr_pkg::IRQ_EN_ON;
    end
  end

  // line follows the sensed beam on an interrupt-type gun while enabled
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      lgi_q <= 1'b0;
      BUSY_OUT <= 1'b0;
      IRQ_EN_OUT <= 1'b0;
    end else begin
      lgi_q <= type_s & irq_en_q & lt_s;
      BUSY_OUT <= act_q;
      IRQ_EN_OUT <= irq_en_q;
    end
  end

  assign LINK.dat_o = 1'b0;
  assign LINK.dat_oe = oe_q;
  assign LINK.lightgun_interrupt = lgi_q;
endmodule

// >>> rtl/lgr_host.sv
`timescale 1ns/100ps
module lgr_host (
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  lgr_if.host LINK,
  input wire logic [7:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  output logic IRQ_OUT
);
  ////////////////////////////////////////////////////////////////////////
  logic [1:0] s;
  logic [1:0] r;
  lgr_sync #(.W(2), .INIT(2'h1)) u_sync (
    .clk_in(CLK_IN),
    .srst_in(SRST_IN),
    .d_in({LINK.lightgun_interrupt, LINK.dat}),
    .q_out(s),
    .rise_out(r),
    .fall_out()
  );

  ////////////////////////////////////////////////////////////////////////
  lgr_pkg::lgr_hstate_t st_q;
  logic [7:0] cnt_q;
  logic [2:0] bit_q;
  logic [3:0] byte_q;
  logic long_q;
  logic [7:0] en_q;
  logic [7:0] rx_q [0:8];
  logic sel_n_q;
  logic sck_q;
  logic cmd_q;
  logic done;
  logic start;
  logic [3:0] last;
  logic [7:0] tx_cur;

  assign start = WR_IN && ADDR_IN == lgr_pkg::A_CTRL && WDATA_IN[lgr_pkg::CTRL_START];
  assign last = (long_q ? lgr_pkg::LEN_LONG : lgr_pkg::LEN_SHORT) - 4'h1;
  assign done = st_q == lgr_pkg::H_HIGH && cnt_q == 8'h00 && bit_q == 3'h7
    && byte_q == last;

  function automatic logic [7:0] tx_byte(input logic [3:0] idx);
    unique case (idx)
      4'h0: tx_byte = lgr_pkg::CMD_START;
      4'h1: tx_byte = lgr_pkg::CMD_READ;
      4'h3: tx_byte = en_q;
      default: tx_byte = lgr_pkg::IDLE_BYTE;
    endcase
  endfunction

  assign tx_cur = tx_byte(byte_q);

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      long_q <= 1'b0;
      en_q <= lgr_pkg::IRQ_EN_OFF;
    end else if (WR_IN && ADDR_IN == lgr_pkg::A_CTRL) begin
      long_q <= WDATA_IN[lgr_pkg::CTRL_LONG];
      en_q <= WDATA_IN[lgr_pkg::CTRL_EN_LSB +: 8];
    end
  end

  // software picks the poll moment and gun count per frame
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      st_q <= lgr_pkg::H_IDLE;
      cnt_q <= 8'h00;
      bit_q <= 3'h0;
      byte_q <= 4'h0;
      sel_n_q <= 1'b1;
      sck_q <= 1'b1;
      cmd_q <= 1'b1;
    end else begin
      cnt_q <= (cnt_q == 8'h00) ? 8'h00 : cnt_q - 8'h01;
      unique case (st_q)
        lgr_pkg::H_IDLE: begin
          if (start) begin
            st_q <= lgr_pkg::H_GAP;
            sel_n_q <= 1'b0;
            byte_q <= 4'h0;
            bit_q <= 3'h0;
            cnt_q <= 8'(lgr_pkg::SCK_HALF_CYC);
          end
        end
        lgr_pkg::H_GAP: begin
          if (cnt_q == 8'h00) begin
            st_q <= lgr_pkg::H_LOW;
            sck_q <= 1'b0;
            cmd_q <= tx_cur[bit_q];
            cnt_q <= 8'(lgr_pkg::SCK_HALF_CYC);
          end
        end
        lgr_pkg::H_LOW: begin
          if (cnt_q == 8'h00) begin
            st_q <= lgr_pkg::H_HIGH;
            sck_q <= 1'b1;
            cnt_q <= 8'(lgr_pkg::SCK_HALF_CYC);
          end
        end
        lgr_pkg::H_HIGH: begin
          if (cnt_q == 8'h00) begin
            bit_q <= bit_q + 3'h1;
            cnt_q <= 8'(lgr_pkg::SCK_HALF_CYC);
            if (done) begin
              st_q <= lgr_pkg::H_IDLE;
              sel_n_q <= 1'b1;
              cmd_q <= 1'b1;
            end else if (bit_q == 3'h7) begin
              st_q <= lgr_pkg::H_GAP;
              byte_q <= byte_q + 4'h1;
            end else begin
              st_q <= lgr_pkg::H_LOW;
              sck_q <= 1'b0;
              cmd_q <= tx_cur[bit_q + 3'h1];
            end
          end
        end
      endcase
    end
  end

  // sample at the end of the high phase, after sync latency
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      for (int i = 0; i < 9; i++) begin
        rx_q[i] <= 8'h00;
      end
    end else if (st_q == lgr_pkg::H_HIGH && cnt_q == 8'h00) begin
      rx_q[byte_q][bit_q] <= s[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic [1:0] ist_q;
  logic [1:0] imask_q;
  logic [1:0] ev;

  // gun line latched at once so late servicing loses nothing
  assign ev = {r[1], done};

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      ist_q <= 2'h0;
      imask_q <= 2'h0;
    end else begin
      if (WR_IN && ADDR_IN == lgr_pkg::A_IMASK) begin
        imask_q <= WDATA_IN[1:0];
      end
      if (WR_IN && ADDR_IN == lgr_pkg::A_ISTAT) begin
        ist_q <= (ist_q & ~WDATA_IN[1:0]) | ev;
      end else begin
        ist_q <= ist_q | ev;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      RDATA_OUT <= 32'h00000000;
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |(ist_q & imask_q);
      RDATA_OUT <= 32'h00000000;
      if (RD_IN) begin
        unique case (ADDR_IN)
          lgr_pkg::A_CTRL: RDATA_OUT <= {16'h0000, en_q, 6'h00, long_q, 1'b0};
          lgr_pkg::A_STAT: RDATA_OUT <= {31'h00000000, !st_q[0]};
          lgr_pkg::A_ID: RDATA_OUT <= {16'h0000, rx_q[2], rx_q[1]};
          lgr_pkg::A_BTN: RDATA_OUT <= {16'h0000, rx_q[4], rx_q[3]};
          lgr_pkg::A_XPOS: RDATA_OUT <= {16'h0000, rx_q[6], rx_q[5]};
          lgr_pkg::A_YPOS: RDATA_OUT <= {16'h0000, rx_q[8], rx_q[7]};
          lgr_pkg::A_ISTAT: RDATA_OUT <= {30'h00000000, ist_q};
          lgr_pkg::A_IMASK: RDATA_OUT <= {30'h00000000, imask_q};
          default: RDATA_OUT <= 32'h00000000;
        endcase
      end
    end
  end

  assign LINK.sel_n = sel_n_q;
  assign LINK.sck = sck_q;
  assign LINK.cmd = cmd_q;
endmodule

// >>> verif/lgr_assertions.sv
`timescale 1ns/100ps
module lgr_checker (
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  input wire logic sel_n,
  input wire logic sck,
  input wire logic cmd,
  input wire logic dat_o,
  input wire logic dat_oe,
  input wire logic dat,
  input wire logic lightgun_interrupt
);
  // cycles since select, saturating
  logic [7:0] sel_cnt_q;
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN || sel_n) begin
      sel_cnt_q <= 8'h00;
    end else if (sel_cnt_q != 8'hFF) begin
      sel_cnt_q <= sel_cnt_q + 8'h01;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  open_drain_a: assert property (dat_o == 1'b0)
    else $error("gun drives data high");
  idle_release_a: assert property (sel_n [*8] |-> !dat_oe)
    else $error("data held while deselected");
  sck_idle_a: assert property (sel_n |-> sck)
    else $error("link clock low while deselected");
  select_gap_a: assert property ($fell(sel_n) |-> sck [*8])
    else $error("no gap after select");
  low_phase_a: assert property ($fell(sck) |=> (!sck) [*6] ##[1:3] sck)
    else $error("link clock low phase length wrong");
  high_phase_a: assert property ($rose(sck) && !sel_n |=> sck [*6])
    else $error("link clock high phase too short");
  drive_low_a: assert property ($rose(dat_oe) && !sel_n |-> !sck)
    else $error("data changed in high phase");
  first_byte_a: assert property (
    !sel_n && sel_cnt_q >= 8'h05 && sel_cnt_q <= 8'h8C |-> !dat_oe)
    else $error("first reply byte not released");
endmodule

// >>> verif/lightgun_position_responder_bench.sv
`timescale 1ns/100ps
module lightgun_position_responder_bench;
  logic clk, srst, wr, rd, hsync, vsync, light, trig_n, left_n, right_n, irq_type;
  logic irq, busy, irq_en;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v;
  int failures, samples_checked;
  lgr_if lnk();
  lgr_gun i_lgr_gun (.CLK_IN(clk), .SRST_IN(srst), .LINK(lnk), .HSYNC_IN(hsync),
    .VSYNC_IN(vsync), .LIGHT_IN(light), .TRIGGER_N_IN(trig_n), .LEFT_N_IN(left_n),
    .RIGHT_N_IN(right_n), .IRQ_TYPE_IN(irq_type), .BUSY_OUT(busy), .IRQ_EN_OUT(irq_en));
  lgr_host i_lgr_host (.CLK_IN(clk), .SRST_IN(srst), .LINK(lnk), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .IRQ_OUT(irq));
  lgr_checker i_lgr_checker (.CLK_IN(clk), .SRST_IN(srst), .sel_n(lnk.sel_n),
    .sck(lnk.sck), .cmd(lnk.cmd), .dat_o(lnk.dat_o), .dat_oe(lnk.dat_oe),
    .dat(lnk.dat), .lightgun_interrupt(lnk.lightgun_interrupt));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // x is counted by an accumulator, so one tick either way is allowed
  task automatic rng(input logic [31:0] got, input int lo, input int hi);
    samples_checked++;
    if ((got >= 32'(lo) && got <= 32'(hi)) !== 1'b1) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, lo);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic poll(input logic lng, input logic [7:0] en);
    wr_reg(lgr_pkg::A_CTRL, {16'h0000, en, 6'h00, lng, 1'b1});
    rd_reg(lgr_pkg::A_STAT);
    chk(v & 32'h1, 32'h1);
    repeat (3) @(posedge clk);
    #1 chk({31'h0, busy}, 32'h1);
    for (int i = 0; i < 2000; i++) begin
      rd_reg(lgr_pkg::A_ISTAT);
      if (v[lgr_pkg::IST_DONE] === 1'b1) break;
    end
    chk(v & 32'h1, 32'h1);
    wr_reg(lgr_pkg::A_ISTAT, 32'h00000001);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, busy}, 32'h0);
  endtask
  task automatic result(input logic [7:0] id, input logic [15:0] btn);
    rd_reg(lgr_pkg::A_ID);
    chk(v, {16'h0000, lgr_pkg::ID_TAIL, id});
    rd_reg(lgr_pkg::A_BTN);
    chk(v, {16'h0000, btn});
  endtask
  task automatic coord(input int xlo, input int xhi, input logic [15:0] y);
    rd_reg(lgr_pkg::A_XPOS);
    rng(v, xlo, xhi);
    rd_reg(lgr_pkg::A_YPOS);
    chk(v, {16'h0000, y});
  endtask
  task automatic scan(input int at);
    for (int i = 0; i < 120; i++) begin
      @(posedge clk);
      hsync <= (i < 4);
      light <= (i >= at && i < at + 3);
    end
  endtask
  // light during vsync starts late so the frame restart is seen first
  task automatic frame(input int ln, input int at, input logic vl);
    @(posedge clk);
    vsync <= 1'b1;
    repeat (3) @(posedge clk);
    light <= vl;
    repeat (7) @(posedge clk);
    vsync <= 1'b0;
    light <= 1'b0;
    for (int l = 1; l < 5; l++) scan(l == ln ? at : 200);
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    conclude();
  end
  initial begin
    {srst, trig_n, left_n, right_n} = 4'hF;
    {wr, rd, hsync, vsync, light, irq_type} = 6'h00;
    addr = 8'h00;
    wdata = 32'h00000000;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    trig_n <= 1'b0;
    frame(0, 200, 1'b0);
    poll(1'b1, 8'h00);
    result(lgr_pkg::ID_VIDEO_LO, 16'hFFFF ^ (16'h1 << lgr_pkg::BTN_V_TRIG));
    coord(1, 1, lgr_pkg::ERR_Y_NONE);
    $display("no light frame done");
    {trig_n, left_n, right_n} <= 3'b100;
    frame(3, 100, 1'b0);
    poll(1'b1, 8'h00);
    result(lgr_pkg::ID_VIDEO_LO, 16'hFFFF ^ 16'h4008);
    coord(7, 9, 16'h0003);
    $display("hit frame done");
    frame(0, 200, 1'b1);
    poll(1'b1, 8'h00);
    coord(1, 1, lgr_pkg::ERR_Y_VSYNC);
    $display("vsync light done");
    {trig_n, left_n, right_n} <= 3'b111;
    frame(2, 50, 1'b0);
    fork
      poll(1'b1, 8'h00);
      begin
        repeat (20) @(posedge clk);
        frame(1, 100, 1'b0);
      end
    join
    coord(3, 5, 16'h0002);
    $display("frozen pair done");
    {irq_type, trig_n, left_n} <= 3'b100;
    poll(1'b1, lgr_pkg::IRQ_EN_ON);
    #1 chk({31'h0, irq_en}, 32'h1);
    result(lgr_pkg::ID_IRQ_LO, 16'hFFFF ^ 16'h8008);
    coord(65535, 65535, 16'hFFFF);
    rd_reg(lgr_pkg::A_CTRL);
    chk(v, 32'h00001002);
    rd_reg(8'h20);
    chk(v, 32'h00000000);
    wr_reg(lgr_pkg::A_IMASK, 32'h00000002);
    @(posedge clk);
    light <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk({31'h0, lnk.lightgun_interrupt}, 32'h1);
    @(posedge clk);
    light <= 1'b0;
    rd_reg(lgr_pkg::A_ISTAT);
    chk(v & 32'h2, 32'h2);
    #1 chk({31'h0, irq}, 32'h1);
    wr_reg(lgr_pkg::A_ISTAT, 32'h00000002);
    repeat (3) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h0);
    poll(1'b0, lgr_pkg::IRQ_EN_OFF);
    #1 chk({31'h0, irq_en}, 32'h0);
    @(posedge clk);
    light <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk({31'h0, lnk.lightgun_interrupt}, 32'h0);
    @(posedge clk);
    light <= 1'b0;
    rd_reg(lgr_pkg::A_ISTAT);
    chk(v & 32'h2, 32'h0);
    $display("interrupt gun done");
    conclude();
  end
endmodule
